// *** common/panel_timing_regs.svh ***
// register offsets, field positions and reset values of the panel timing block
`ifndef PANEL_TIMING_REGS_SVH
`define PANEL_TIMING_REGS_SVH

`define PT_ADDR_W        12
`define PT_CTRL_ONE_OFS  12'h400
`define PT_CTRL_TWO_OFS  12'h404
`define PT_MODE_OFS      12'h408
`define PT_STATUS_OFS    12'h40C
`define PT_CTRL_RST      32'h00000000
`define PT_CTRL_ONE_MASK 32'h280000FF
`define PT_CTRL_TWO_MASK 32'h6C000000
`define PT_MODE_MASK     32'h00000001
`define PT_IN_POL_BIT    29
`define PT_EDGE_EN_BIT   27
`define PT_LEAD_HI       7
`define PT_LEAD_LO       5
`define PT_TRAIL_HI      4
`define PT_TRAIL_LO      0
`define PT_BYPASS_BIT    30
`define PT_DE_POL_BIT    29
`define PT_RETRACE_BIT   27
`define PT_LP_SEL_BIT    26
`define PT_MODE_BIT      0
`define PT_STAT_SYNC_BIT 8
`define PT_STAT_ACT_BIT  9
`define PT_STAT_FULL_BIT 10
`define PT_LEAD_STEP     5'h01
`define PT_CNT_MAX       5'h1F
`define PT_PIX_W         18
`define PT_FIFO_DEPTH    16

`endif

// *** common/panel_timing_pkg.sv ***
// shared types of the panel timing block
package panel_timing_pkg;
    typedef logic [17:0] pixel_t;
    typedef enum logic {PANEL_TFT, PANEL_STN} panel_kind_t;
endpackage

// *** common/pix_stream_if.sv ***
// pixel stream carrier between the timing core and its fifo
`timescale 1ns/1ps
interface pix_stream_if #(parameter int W = 18, parameter int LW = 5);
    logic          wr_valid;
    logic          wr_ready;
    logic [W-1:0]  wr_data;
    logic          rd_valid;
    logic          rd_ready;
    logic [W-1:0]  rd_data;
    logic [LW-1:0] level;
    modport fifo (input wr_valid, wr_data, rd_ready,
                  output wr_ready, rd_valid, rd_data, level);
    modport user (output wr_valid, wr_data, rd_ready,
                  input wr_ready, rd_valid, rd_data, level);
endinterface

// *** design/pixel_fifo.sv ***
// parameterised pixel fifo with valid and ready on both sides
`timescale 1ns/1ps
module pixel_fifo #(
    parameter int W = 18,
    parameter int D = 16
) (
    input wire logic pclk,
    input wire logic presetn,
    pix_stream_if.fifo s
);
    localparam int AW = $clog2(D);
    logic [W-1:0] mem [D];
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0]   cnt;
    logic          space;
    logic          do_wr;
    logic          do_rd;

    // ready is its own flop so the top's pixel_ready leaves a register
    assign s.wr_ready = space;
    assign s.rd_valid = (cnt != '0);
    assign s.rd_data  = mem[rp];
    assign s.level    = cnt[AW:0];
    assign do_wr      = s.wr_valid & space;
    assign do_rd      = s.rd_ready & s.rd_valid;

    // storage has no reset; only pointers, count and space flag carry state
    always_ff @(posedge pclk) begin
        if (do_wr) begin
            mem[wp] <= s.wr_data;
        end
    end

    // pointers wrap naturally since depth is a power of two
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wp   <= '0;
            rp   <= '0;
            cnt  <= '0;
            space <= 1'b1;
        end else begin
            if (do_wr) wp <= wp + 1'b1;
            if (do_rd) rp <= rp + 1'b1;
            cnt  <= cnt + (AW+1)'(do_wr) - (AW+1)'(do_rd);
            space <= (cnt + (AW+1)'(do_wr) - (AW+1)'(do_rd)) != (AW+1)'(D);
        end
    end

    chk_full_blocks_write: assert property (@(posedge pclk) disable iff (!presetn)
        !space |=> $stable(wp))
        else $error("fifo accepted a word while full");
endmodule // pixel_fifo

// *** design/sync_edge_gen.sv ***
// programmable line-sync pulse placer counting pixel clocks
`timescale 1ns/1ps
`include "panel_timing_regs.svh"
module sync_edge_gen (
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic       pix_en,
    input  wire logic       sync_mod,
    input  wire logic       edge_en,
    input  wire logic [2:0] lead_field,
    input  wire logic [4:0] trail_field,
    output logic            line_sync_out
);
    logic       sync_d;
    logic       rise;
    logic       running;
    logic [4:0] cnt;
    logic [4:0] next_cnt;
    logic [4:0] lead_pos;

    // leading edge: zero means none, otherwise two to eight clocks
    assign lead_pos = (lead_field == 3'h0) ? 5'h00 : ({2'h0, lead_field} + `PT_LEAD_STEP);
    assign rise     = pix_en & sync_mod & ~sync_d;
    assign next_cnt = rise ? 5'h00 : ((cnt == `PT_CNT_MAX) ? cnt : cnt + 5'h01);

    // counter restarts on each modified rising edge, saturates after
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync_d  <= 1'b0;
            cnt     <= `PT_CNT_MAX;
            running <= 1'b0;
        end else if (pix_en) begin
            sync_d  <= sync_mod;
            cnt     <= next_cnt;
            if (rise) running <= 1'b1;
        end
    end

    // pulse spans lead..trail; empty or inverted window gives nothing
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            line_sync_out <= 1'b0;
        end else if (pix_en) begin
            if (!edge_en) begin
                line_sync_out <= (trail_field != 5'h00) & sync_mod;
            end else begin
                line_sync_out <= (running | rise) && (next_cnt >= lead_pos)
                                 && (next_cnt < trail_field);
            end
        end
    end

    chk_negative_no_pulse: assert property (@(posedge pclk) disable iff (!presetn)
        edge_en && pix_en && (trail_field <= lead_pos) |=> !line_sync_out)
        else $error("pulse emitted for empty window");
    chk_zero_trail_idle: assert property (@(posedge pclk) disable iff (!presetn)
        !edge_en && pix_en && (trail_field == 5'h00) |=> !line_sync_out)
        else $error("pulse emitted with zero trailing field");
    chk_trail_edge_place: assert property (@(posedge pclk) disable iff (!presetn)
        edge_en && pix_en && (next_cnt == trail_field) && (trail_field > lead_pos)
        |=> !line_sync_out)
        else $error("trailing edge misplaced");
    chk_count_restart: assert property (@(posedge pclk) disable iff (!presetn)
        rise |=> (cnt == 5'h00))
        else $error("counter did not restart");
endmodule // sync_edge_gen

// *** design/panel_sync_output_timing.sv ***
// panel output timing core with apb registers, sync placement and bypass
`timescale 1ns/1ps
`include "panel_timing_regs.svh"

// Summary of operation
// - trailing edge of output sync lands 1 to 31 pixel clocks after edge
// - edge positions count from rising edge of polarity-adjusted input sync
// - zero or negative pulse length produces no output sync pulse
// - trailing field needs enable bit; zero field and clear bit give no pulse
// - bypass routes incoming pixels and timing straight to panel pins
// - edge fields, strobe polarity and upper control bits act only in normal mode
// - display enable strobe active low when polarity bit is 0, else high
// - retrace bit 0 runs shift clock in active display only, 1 always
// - in stn panel modes the retrace bit has no effect
// - select bit 1 drives shared pin with tft line sync instead
// - input polarity 0 means idle low pulse high, 1 idle high pulse low
// - leading edge field zero means no delay, else 2 to 8 clocks
module panel_sync_output_timing #(
    parameter int PIX_W = `PT_PIX_W,
    parameter int DEPTH = `PT_FIFO_DEPTH
) (
    input  wire logic                    pclk,
    input  wire logic                    presetn,
    input  wire logic [`PT_ADDR_W-1:0]   paddr,
    input  wire logic                    psel,
    input  wire logic                    penable,
    input  wire logic                    pwrite,
    input  wire logic [31:0]             pwdata,
    output logic      [31:0]             prdata,
    output logic                         pready,
    output logic                         pslverr,
    input  wire logic                    pixel_clock,
    input  wire logic                    incoming_line_sync,
    input  wire logic                    display_active_in,
    input  wire logic [PIX_W-1:0]        pixel_data_in,
    input  wire logic                    line_pulse,
    output logic                         pixel_ready,
    output logic      [PIX_W-1:0]        panel_data,
    output logic                         panel_shift_clock,
    output logic                         display_enable_strobe,
    output logic                         line_sync_pin
);
    localparam int SW = PIX_W + 3;
    localparam int LW = $clog2(DEPTH) + 1;

    logic [31:0]      ctrl_one;
    logic [31:0]      ctrl_two;
    logic [31:0]      mode_reg;
    logic [SW-1:0]    pin_meta;
    logic [SW-1:0]    pin_sync;
    logic             pclk_d;
    logic             pix_en;
    logic             pclk_s;
    logic             sync_s;
    logic             act_s;
    logic [PIX_W-1:0] data_s;
    logic             sync_mod;
    logic             gen_sync;
    logic             shift_run;
    logic             shift_rise;
    logic             setup;
    logic             access;
    logic             hit;
    logic [31:0]      rd_mux;
    logic             bypass;
    logic             de_pol;
    logic             retrace;
    logic             lp_sel;
    logic             in_pol;
    logic             edge_en;
    panel_timing_pkg::panel_kind_t kind;

    pix_stream_if #(.W(PIX_W), .LW(LW)) fs ();

    // decoded control fields
    assign bypass  = ctrl_two[`PT_BYPASS_BIT];
    assign de_pol  = ctrl_two[`PT_DE_POL_BIT];
    assign retrace = ctrl_two[`PT_RETRACE_BIT];
    assign lp_sel  = ctrl_two[`PT_LP_SEL_BIT];
    assign in_pol  = ctrl_one[`PT_IN_POL_BIT];
    assign edge_en = ctrl_one[`PT_EDGE_EN_BIT];
    assign kind    = panel_timing_pkg::panel_kind_t'(mode_reg[`PT_MODE_BIT]);

    // apb phases
    assign setup  = psel & ~penable;
    assign access = psel & penable & pready;

    // offset match drives only the error response, for reads and writes alike
    function automatic logic mapped(input logic [`PT_ADDR_W-1:0] a);
        mapped = (a == `PT_CTRL_ONE_OFS) || (a == `PT_CTRL_TWO_OFS)
              || (a == `PT_MODE_OFS) || (a == `PT_STATUS_OFS);
    endfunction

    assign hit = mapped(paddr);

    // read mux; status word shows fifo level and live pin states
    always_comb begin
        rd_mux = 32'h00000000;
        case (paddr)
            `PT_CTRL_ONE_OFS: rd_mux = ctrl_one;
            `PT_CTRL_TWO_OFS: rd_mux = ctrl_two;
            `PT_MODE_OFS:     rd_mux = mode_reg;
            `PT_STATUS_OFS: begin
                rd_mux[LW-1:0] = fs.level;
                rd_mux[`PT_STAT_SYNC_BIT] = line_sync_pin;
                rd_mux[`PT_STAT_ACT_BIT]  = act_s;
                rd_mux[`PT_STAT_FULL_BIT] = ~fs.wr_ready;
            end
            default:          rd_mux = 32'h00000000;
        endcase
    end

    // one wait-free access phase: ready raised right after setup
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h00000000;
        end else begin
            pready  <= setup;
            pslverr <= setup & ~hit;
            if (setup && !pwrite) begin
                prdata <= rd_mux;
            end
        end
    end

    // register writes take effect only at the completing edge
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_one <= `PT_CTRL_RST;
            ctrl_two <= `PT_CTRL_RST;
            mode_reg <= `PT_CTRL_RST;
        end else if (access && pwrite) begin
            case (paddr)
                `PT_CTRL_ONE_OFS: ctrl_one <= pwdata & `PT_CTRL_ONE_MASK;
                `PT_CTRL_TWO_OFS: ctrl_two <= pwdata & `PT_CTRL_TWO_MASK;
                `PT_MODE_OFS:     mode_reg <= pwdata & `PT_MODE_MASK;
                default:          ;
            endcase
        end
    end

    // two-stage synchroniser for the pixel clock, line sync, display active and pixel data pins
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_meta <= '0;
            pin_sync <= '0;
        end else begin
            pin_meta <= {pixel_clock, incoming_line_sync, display_active_in, pixel_data_in};
            pin_sync <= pin_meta;
        end
    end

    assign pclk_s = pin_sync[SW-1];
    assign sync_s = pin_sync[SW-2];
    assign act_s  = pin_sync[SW-3];
    assign data_s = pin_sync[PIX_W-1:0];

    // pixel clock edge becomes a one-cycle enable; needs pclk well above it
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pclk_d <= 1'b0;
        end else begin
            pclk_d <= pclk_s;
        end
    end

    assign pix_en   = pclk_s & ~pclk_d;
    assign sync_mod = sync_s ^ in_pol;

    sync_edge_gen u_edge (
        .pclk          (pclk),
        .presetn       (presetn),
        .pix_en        (pix_en),
        .sync_mod      (sync_mod),
        .edge_en       (edge_en),
        .lead_field    (ctrl_one[`PT_LEAD_HI:`PT_LEAD_LO]),
        .trail_field   (ctrl_one[`PT_TRAIL_HI:`PT_TRAIL_LO]),
        .line_sync_out (gen_sync)
    );

    // pixels enter the fifo only in normal mode while display is active
    assign fs.wr_valid = pix_en & act_s & ~bypass;
    assign fs.wr_data  = data_s;
    assign pixel_ready = fs.wr_ready;

    pixel_fifo #(.W(PIX_W), .D(DEPTH)) u_fifo (
        .pclk    (pclk),
        .presetn (presetn),
        .s       (fs)
    );

    // stn ignores the retrace bit and clocks only active lines
    assign shift_run = (kind == panel_timing_pkg::PANEL_STN) ? act_s
                     : (retrace | act_s);
    assign shift_rise = pix_en & shift_run & ~panel_shift_clock;
    // drain stalls between shift edges, so the fifo really fills
    assign fs.rd_ready = shift_rise & ~bypass;

    // shift clock: pixel clock copy in bypass, else gated half rate
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            panel_shift_clock <= 1'b0;
        end else if (bypass) begin
            panel_shift_clock <= pclk_s;
        end else if (pix_en) begin
            if (shift_run) begin
                panel_shift_clock <= ~panel_shift_clock;
            end else begin
                panel_shift_clock <= 1'b0;
            end
        end
    end

    // panel data: straight pins in bypass, fifo words otherwise
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            panel_data <= '0;
        end else if (bypass) begin
            if (pix_en) panel_data <= data_s;
        end else if (fs.rd_ready && fs.rd_valid) begin
            panel_data <= fs.rd_data;
        end
    end

    // strobe polarity applies in normal mode only; bypass passes level
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            display_enable_strobe <= 1'b1;
        end else if (pix_en) begin
            if (bypass) begin
                display_enable_strobe <= act_s;
            end else begin
                display_enable_strobe <= ~(act_s ^ de_pol);
            end
        end
    end

    // shared pin: raw sync in bypass, line pulse or placed sync otherwise
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            line_sync_pin <= 1'b0;
        end else if (bypass) begin
            line_sync_pin <= sync_s;
        end else if (lp_sel) begin
            line_sync_pin <= gen_sync;
        end else begin
            line_sync_pin <= line_pulse;
        end
    end

    sequence s_setup;
        psel && !penable;
    endsequence
    sequence s_access;
        psel && penable && pready;
    endsequence

    chk_apb_ready_next: assert property (@(posedge pclk) disable iff (!presetn)
        s_setup |=> pready)
        else $error("no ready after setup");
    chk_apb_write_lands: assert property (@(posedge pclk) disable iff (!presetn)
        s_access ##0 (pwrite && paddr == `PT_CTRL_TWO_OFS)
        |=> ctrl_two == ($past(pwdata) & `PT_CTRL_TWO_MASK))
        else $error("control write lost");
    chk_bypass_data_path: assert property (@(posedge pclk) disable iff (!presetn)
        bypass && pix_en |=> panel_data == $past(data_s))
        else $error("bypass data not passed through");
    chk_bypass_sync_path: assert property (@(posedge pclk) disable iff (!presetn)
        bypass |=> line_sync_pin == $past(sync_s))
        else $error("bypass sync altered");
    chk_strobe_polarity: assert property (@(posedge pclk) disable iff (!presetn)
        !bypass && pix_en |=> display_enable_strobe == ($past(act_s) ~^ $past(de_pol)))
        else $error("strobe polarity wrong");
    chk_line_select: assert property (@(posedge pclk) disable iff (!presetn)
        !bypass && lp_sel |=> line_sync_pin == $past(gen_sync))
        else $error("shared pin not driven by line sync");
    chk_shift_stopped: assert property (@(posedge pclk) disable iff (!presetn)
        (!bypass && !retrace && !act_s && kind == panel_timing_pkg::PANEL_TFT) [*2]
        |-> !panel_shift_clock || $stable(panel_shift_clock))
        else $error("shift clock ran during retrace");
    chk_stn_ignores_retrace: assert property (@(posedge pclk) disable iff (!presetn)
        !bypass && pix_en && !act_s && kind == panel_timing_pkg::PANEL_STN
        |=> !panel_shift_clock)
        else $error("stn shift clock ran in retrace");
endmodule // panel_sync_output_timing

// *** dv/panel_model.sv ***
// passive panel model: counts shift clock rises and latches the pixel on each
`timescale 1ns/1ps
module panel_model (
    input  wire logic                     pclk,
    input  wire logic                     presetn,
    input  wire panel_timing_pkg::pixel_t panel_data,
    input  wire logic                     panel_shift_clock,
    output int                            rises,
    output panel_timing_pkg::pixel_t      seen
);
    logic shift_q;

    // a panel only listens; edges are found on the system clock since the
    // shift clock is a registered output of the same domain
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            shift_q <= 1'b0;
            rises   <= 0;
            seen    <= '0;
        end else begin
            shift_q <= panel_shift_clock;
            if (panel_shift_clock && !shift_q) begin
                rises <= rises + 1;
                seen  <= panel_data;
            end
        end
    end
endmodule // panel_model

// *** dv/panel_sync_output_timing_test.sv ***
// self-checking bench for the panel output timing block
`timescale 1ns/1ps
`include "panel_timing_regs.svh"
module panel_sync_output_timing_test;
    logic                     pclk = 1'b0;
    logic                     presetn = 1'b0;
    logic [`PT_ADDR_W-1:0]    paddr = 12'h000;
    logic                     psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [31:0]              pwdata = 32'h00000000;
    logic [31:0]              prdata, rd;
    logic                     pready, pslverr, err, full_seen;
    logic                     pixel_clock = 1'b0, incoming_line_sync = 1'b0;
    logic                     display_active_in = 1'b0, line_pulse = 1'b0;
    panel_timing_pkg::pixel_t pixel_data_in = 18'h00000;
    panel_timing_pkg::pixel_t panel_data, rise_data, seen;
    logic                     pixel_ready, panel_shift_clock;
    logic                     display_enable_strobe, line_sync_pin;
    int                       rises, sync_hi, error_cnt = 0, check_count = 0;

    panel_sync_output_timing u_panel_sync_output_timing (
        .pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata,
        .pready, .pslverr, .pixel_clock, .incoming_line_sync, .display_active_in,
        .pixel_data_in, .line_pulse, .pixel_ready, .panel_data,
        .panel_shift_clock, .display_enable_strobe, .line_sync_pin);

    panel_model u_panel_model (
        .pclk, .presetn, .panel_data, .panel_shift_clock, .rises, .seen);

    // 250 MHz system clock
    always #2 pclk = ~pclk;

    task automatic finish_test();
        $display("checks %0d errors %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
        check_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] %0t %s: got %h want %h", $time, what, got, exp);
        end
    endtask

    task automatic chk1(input logic got, input logic exp, input string what);
        check({31'h0, got}, {31'h0, exp}, what);
    endtask

    // one apb transfer; the wait for pready is bounded
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) begin
            error_cnt++;
            finish_test();
        end
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask

    task automatic rchk(input logic [11:0] a, input logic [31:0] exp, input string what);
        apb(1'b0, a, 32'h00000000);
        check(rd, exp, what);
    endtask

    // pixel clock periods of 8 system clocks; data moves in the low half so it
    // is stable through the synchroniser when the rise is seen
    task automatic pix(input int n);
        repeat (n) begin
            pixel_clock <= 1'b1;
            rise_data = pixel_data_in;
            repeat (4) @(posedge pclk);
            pixel_clock   <= 1'b0;
            pixel_data_in <= pixel_data_in + 18'h00001;
            repeat (4) @(posedge pclk);
            if (line_sync_pin === 1'b1) sync_hi++;
            if (pixel_ready === 1'b0) full_seen = 1'b1;
        end
    endtask

    task automatic reset_scn();
        chk1(display_enable_strobe, 1'b1, "strobe idle after reset");
        chk1(line_sync_pin, 1'b0, "no sync after reset");
        chk1(pixel_ready, 1'b1, "fifo ready after reset");
        rchk(`PT_CTRL_TWO_OFS, `PT_CTRL_RST, "timing two reset");
        rchk(`PT_CTRL_ONE_OFS, `PT_CTRL_RST, "timing one reset");
        wr(`PT_CTRL_TWO_OFS, 32'hFFFFFFFF);
        rchk(`PT_CTRL_TWO_OFS, `PT_CTRL_TWO_MASK, "timing two bits");
        rchk(12'h500, 32'h00000000, "unmapped read");
        chk1(err, 1'b1, "unmapped error");
    endtask

    // idle, then a pulse of w pixel clocks; count high samples over a line
    task automatic sync_case(input logic [31:0] c1, input int w, input int e);
        wr(`PT_CTRL_ONE_OFS, c1);
        incoming_line_sync <= c1[`PT_IN_POL_BIT];
        pix(40);
        sync_hi = 0;
        incoming_line_sync <= !c1[`PT_IN_POL_BIT];
        pix(w);
        incoming_line_sync <= c1[`PT_IN_POL_BIT];
        pix(40 - w);
        check(sync_hi, e, "sync pulse width");
    endtask

    task automatic sync_scn();
        wr(`PT_CTRL_TWO_OFS, 32'h04000000);
        sync_case(32'h08000001, 2, 1);
        sync_case(32'h0800001F, 2, 31);
        sync_case(32'h0800006A, 2, 6);
        sync_case(32'h08000025, 2, 3);
        sync_case(32'h080000E5, 2, 0);
        sync_case(32'h08000085, 2, 0);
        sync_case(32'h000000A0, 3, 0);
        sync_case(32'h00000009, 3, 3);
        sync_case(32'h28000004, 2, 4);
        sync_case(32'h20000009, 5, 5);
        wr(`PT_CTRL_TWO_OFS, 32'h00000000);
        line_pulse <= 1'b1;
        pix(2);
        chk1(line_sync_pin, 1'b1, "line pulse on shared pin");
        line_pulse <= 1'b0;
        pix(2);
        chk1(line_sync_pin, 1'b0, "line pulse released");
    endtask

    task automatic strobe_case(input logic [31:0] c2, input logic act, input logic e);
        wr(`PT_CTRL_TWO_OFS, c2);
        display_active_in <= act;
        pix(3);
        chk1(display_enable_strobe, e, "strobe level");
    endtask

    task automatic strobe_scn();
        strobe_case(32'h04000000, 1'b1, 1'b0);
        strobe_case(32'h04000000, 1'b0, 1'b1);
        strobe_case(32'h24000000, 1'b1, 1'b1);
        strobe_case(32'h24000000, 1'b0, 1'b0);
        strobe_case(32'h64000000, 1'b0, 1'b0);
        strobe_case(32'h44000000, 1'b1, 1'b1);
    endtask

    // two warm-up pixels let the activity flag settle before counting
    task automatic shift_case(input logic [31:0] c2, input logic stn, input logic act, input int e);
        int base;
        wr(`PT_MODE_OFS, {31'h0, stn});
        wr(`PT_CTRL_TWO_OFS, c2);
        display_active_in <= act;
        pix(2);
        base = rises;
        pix(8);
        check(rises - base, e, "shift clock rises");
    endtask

    task automatic shift_scn();
        shift_case(32'h04000000, 1'b0, 1'b0, 0);
        shift_case(32'h04000000, 1'b0, 1'b1, 4);
        shift_case(32'h0C000000, 1'b0, 1'b0, 4);
        shift_case(32'h08000000, 1'b1, 1'b0, 0);
        shift_case(32'h4C000000, 1'b0, 1'b0, 8);
        check({14'h0, panel_data}, {14'h0, rise_data}, "bypass pixel");
    endtask

    // fill until refused, then free-run the shift clock to drain it
    task automatic fifo_scn();
        int n;
        panel_timing_pkg::pixel_t last;
        wr(`PT_MODE_OFS, 32'h00000000);
        wr(`PT_CTRL_TWO_OFS, 32'h04000000);
        display_active_in <= 1'b1;
        full_seen = 1'b0;
        n = 0;
        while (!full_seen && n < 80) begin
            pix(1);
            n++;
        end
        chk1(full_seen, 1'b1, "fifo refuses when full");
        last = rise_data;
        apb(1'b0, `PT_STATUS_OFS, 32'h00000000);
        check(rd & 32'h0000041F, 32'h00000410, "full level");
        display_active_in <= 1'b0;
        wr(`PT_CTRL_TWO_OFS, 32'h0C000000);
        n = 0;
        do begin
            pix(2);
            apb(1'b0, `PT_STATUS_OFS, 32'h00000000);
            n++;
        end while (rd[4:0] !== 5'h00 && n < 40);
        check(rd & 32'h0000041F, 32'h00000000, "drained level");
        check({14'h0, seen}, {14'h0, last}, "last drained pixel");
        chk1(pixel_ready, 1'b1, "ready after drain");
    endtask

    // reset held six cycles, then every scenario in turn
    initial begin
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        reset_scn();
        sync_scn();
        strobe_scn();
        shift_scn();
        fifo_scn();
        finish_test();
    end
endmodule // panel_sync_output_timing_test
